// ===== hdl/gpm_pkg.sv
package gpm_pkg;
   // Port geometry.
   localparam int NUM_PINS = 8;
   localparam int SEL_W = 4;
   localparam int NUM_FUNCS = 16;
   localparam int MODE_W = 3;
   localparam int PAD_W = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets.
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_SELECT = 8'h04;
   localparam logic [7:0] OFS_DIR = 8'h08;
   localparam logic [7:0] OFS_SENSE = 8'h0c;
   localparam logic [7:0] OFS_DISCRETE = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;
   localparam logic [7:0] OFS_RAW_STAT = 8'h18;
   localparam logic [7:0] OFS_MASK_STAT = 8'h1c;
   localparam logic [7:0] OFS_DMA_EN = 8'h20;
   localparam logic [7:0] OFS_STRENGTH = 8'h24;
   localparam logic [7:0] OFS_DRV_TYPE = 8'h28;
   localparam logic [7:0] OFS_MUX = 8'h2c;

   // Field positions inside a sense write word.
   localparam int SENSE_MODE_LSB = 0;
   localparam int SENSE_DISC_BIT = 3;

   // Interrupt sense encodings.
   localparam logic [2:0] SENSE_FALLING = 3'h0;
   localparam logic [2:0] SENSE_RISING = 3'h1;
   localparam logic [2:0] SENSE_BOTH = 3'h2;
   localparam logic [2:0] SENSE_LOW = 3'h3;
   localparam logic [2:0] SENSE_HIGH = 3'h4;

   // Pad drive types.
   localparam logic [1:0] DRV_PUSH_PULL = 2'h0;
   localparam logic [1:0] DRV_PULL_UP = 2'h1;
   localparam logic [1:0] DRV_PULL_DOWN = 2'h2;
   localparam logic [1:0] DRV_OPEN_DRAIN = 2'h3;

   // Mux selection zero keeps the pin on the port's own data logic.
   localparam logic [3:0] MUX_GPIO = 4'h0;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [23:0] RST_SENSE = 24'h000000;
   localparam logic [15:0] RST_PAD = 16'h0000;
   localparam logic [31:0] RST_MUX = 32'h00000000;
   localparam logic [31:0] RST_WORD = 32'h00000000;
endpackage

// ===== hdl/gpm_port.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module gpm_port
   import gpm_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic [gpm_pkg::ADDR_W-1:0] ADDR,
   input wire logic [gpm_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [gpm_pkg::DATA_W-1:0] RDATA,
   input wire logic [gpm_pkg::NUM_PINS-1:0] PAD_IN,
   output logic [gpm_pkg::NUM_PINS-1:0] PAD_OUT,
   output logic [gpm_pkg::NUM_PINS-1:0] PAD_OE,
   output logic [2*gpm_pkg::NUM_PINS-1:0] PAD_STRENGTH,
   output logic [2*gpm_pkg::NUM_PINS-1:0] PAD_TYPE,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] PERIPH_OUT,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] PERIPH_OE,
   output logic [gpm_pkg::NUM_FUNCS-1:0] PERIPH_IN,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] PEER_CLAIM,
   output logic [gpm_pkg::NUM_FUNCS-1:0] CLAIM_OUT,
   output logic IRQ,
   output logic [gpm_pkg::NUM_PINS-1:0] IRQ_PIN,
   output logic DMA_TRIG
);
   import gpm_pkg::*;

   gpm_sense_if sif ();

   logic [7:0] out_ff, nxt_out;
   logic [7:0] sel_ff, nxt_sel;
   logic [7:0] dir_ff, nxt_dir;
   logic [23:0] sense_ff, nxt_sense;
   logic [7:0] disc_ff, nxt_disc;
   logic [7:0] ien_ff, nxt_ien;
   logic [7:0] stat_ff, nxt_stat;
   logic [7:0] dma_ff, nxt_dma;
   logic [15:0] str_ff, nxt_str;
   logic [15:0] typ_ff, nxt_typ;
   logic [31:0] mux_ff, nxt_mux;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] pout_ff, nxt_pout;
   logic [7:0] poe_ff, nxt_poe;
   logic [15:0] pin_ff, nxt_pin;
   logic [15:0] claim_ff, nxt_claim;
   logic irq_ff, nxt_irq;
   logic [7:0] irqp_ff, nxt_irqp;
   logic dma_trig_ff, nxt_dma_trig;
   logic [7:0] mux_out;
   logic [7:0] mux_oe;
   logic [15:0] func_in;
   logic [15:0] func_claim;
   logic [15:0] str_rb;
   logic [7:0] masked;

   ////////////////////////////////////////////////////////////////////////////
   // Pad synchronising and sense decode live in the detector.
   assign sif.pin_raw = PAD_IN;
   assign sif.mode = sense_ff;

   gpm_sense u_sense (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .sif(sif.det)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin mux: a function claimed by a lower-letter port falls back to GPIO.
   logic [3:0] eff_sel [NUM_PINS];
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_mux
      logic [3:0] req;
      assign req = mux_ff[i*SEL_W +: SEL_W];
      assign eff_sel[i] = (req != MUX_GPIO && PEER_CLAIM[req]) ? MUX_GPIO : req;
      // Only one function index is picked per pin, so nothing else can drive it.
      always_comb
      begin
         if (eff_sel[i] == MUX_GPIO)
         begin
            if (typ_ff[i*PAD_W +: PAD_W] == DRV_OPEN_DRAIN)
            begin
               mux_out[i] = 1'b0;
               mux_oe[i] = dir_ff[i] & ~out_ff[i];
            end
            else
            begin
               mux_out[i] = out_ff[i];
               mux_oe[i] = dir_ff[i];
            end
         end
         else
         begin
            mux_out[i] = PERIPH_OUT[eff_sel[i]];
            mux_oe[i] = PERIPH_OE[eff_sel[i]];
         end
      end
      // Input pins read back no drive strength, though PAD_STRENGTH still carries the stored value.
      assign str_rb[i*PAD_W +: PAD_W] = dir_ff[i] ? str_ff[i*PAD_W +: PAD_W] : 2'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-function input routing; if software maps a signal twice, lowest pin wins.
   for (genvar f = 0; f < NUM_FUNCS; f++)
   begin : g_func
      always_comb
      begin
         func_in[f] = 1'b0;
         func_claim[f] = 1'b0;
         for (int p = NUM_PINS - 1; p >= 0; p--)
         begin
            if (f != 0 && eff_sel[p] == 4'(f))
            begin
               func_in[f] = sif.pin_lvl[p];
               func_claim[f] = 1'b1;
            end
         end
      end
   end

   assign masked = stat_ff & ien_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register file, interrupt status and output staging.
   always_comb
   begin
      nxt_out = out_ff;
      nxt_sel = sel_ff;
      nxt_dir = dir_ff;
      nxt_sense = sense_ff;
      nxt_disc = disc_ff;
      nxt_ien = ien_ff;
      nxt_dma = dma_ff;
      nxt_str = str_ff;
      nxt_typ = typ_ff;
      nxt_mux = mux_ff;
      nxt_stat = stat_ff;
      nxt_rdata = RST_WORD;
      if (WR)
      begin
         unique case (ADDR)
            OFS_DATA: nxt_out = (out_ff & ~sel_ff) | (WDATA[7:0] & sel_ff);
            OFS_SELECT: nxt_sel = WDATA[7:0];
            OFS_DIR: nxt_dir = WDATA[7:0];
            OFS_DISCRETE: nxt_disc = WDATA[7:0];
            OFS_IRQ_EN: nxt_ien = WDATA[7:0];
            OFS_DMA_EN: nxt_dma = WDATA[7:0];
            default: ;
         endcase
         // Grouped settings land only on pins picked by the select mask.
         for (int i = 0; i < NUM_PINS; i++)
         begin
            if (sel_ff[i])
            begin
               if (ADDR == OFS_SENSE)
               begin
                  nxt_sense[i*MODE_W +: MODE_W] = WDATA[SENSE_MODE_LSB +: MODE_W];
                  nxt_disc[i] = WDATA[SENSE_DISC_BIT];
               end
               if (ADDR == OFS_STRENGTH)
                  nxt_str[i*PAD_W +: PAD_W] = WDATA[PAD_W-1:0];
               if (ADDR == OFS_DRV_TYPE)
                  nxt_typ[i*PAD_W +: PAD_W] = WDATA[PAD_W-1:0];
               if (ADDR == OFS_MUX)
                  nxt_mux[i*SEL_W +: SEL_W] = WDATA[SEL_W-1:0];
            end
         end
      end
      if (RD)
      begin
         unique case (ADDR)
            OFS_DATA: nxt_rdata = {24'h000000, sif.pin_lvl & sel_ff};
            OFS_SELECT: nxt_rdata = {24'h000000, sel_ff};
            OFS_DIR: nxt_rdata = {24'h000000, dir_ff};
            OFS_SENSE: nxt_rdata = {8'h00, sense_ff};
            OFS_DISCRETE: nxt_rdata = {24'h000000, disc_ff};
            OFS_IRQ_EN: nxt_rdata = {24'h000000, ien_ff};
            OFS_RAW_STAT: nxt_rdata = {24'h000000, stat_ff};
            OFS_MASK_STAT: nxt_rdata = {24'h000000, masked};
            OFS_DMA_EN: nxt_rdata = {24'h000000, dma_ff};
            OFS_STRENGTH: nxt_rdata = {16'h0000, str_rb};
            OFS_DRV_TYPE: nxt_rdata = {16'h0000, typ_ff};
            OFS_MUX: nxt_rdata = mux_ff;
            default: nxt_rdata = RST_WORD;
         endcase
         // Reading either status view clears it.
         if (ADDR == OFS_RAW_STAT || ADDR == OFS_MASK_STAT)
            nxt_stat = RST_BYTE;
      end
      // Events are applied last so a set in the clearing cycle survives.
      // A held level keeps raising its event, so its bit cannot be cleared.
      nxt_stat = nxt_stat | sif.evt;
      nxt_irq = |(masked & ~disc_ff);
      nxt_irqp = masked & disc_ff;
      // The trigger is independent of the interrupt enable.
      nxt_dma_trig = |(sif.evt & dma_ff);
      nxt_pout = mux_out;
      nxt_poe = mux_oe;
      nxt_pin = func_in;
      nxt_claim = func_claim;
   end

   // All state takes its reset constant; every output is a flop.
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         out_ff <= RST_BYTE;
         sel_ff <= RST_BYTE;
         dir_ff <= RST_BYTE;
         sense_ff <= RST_SENSE;
         disc_ff <= RST_BYTE;
         ien_ff <= RST_BYTE;
         stat_ff <= RST_BYTE;
         dma_ff <= RST_BYTE;
         str_ff <= RST_PAD;
         typ_ff <= RST_PAD;
         mux_ff <= RST_MUX;
         rdata_ff <= RST_WORD;
         pout_ff <= RST_BYTE;
         poe_ff <= RST_BYTE;
         pin_ff <= RST_PAD;
         claim_ff <= RST_PAD;
         irq_ff <= 1'b0;
         irqp_ff <= RST_BYTE;
         dma_trig_ff <= 1'b0;
      end
      else
      begin
         out_ff <= nxt_out;
         sel_ff <= nxt_sel;
         dir_ff <= nxt_dir;
         sense_ff <= nxt_sense;
         disc_ff <= nxt_disc;
         ien_ff <= nxt_ien;
         stat_ff <= nxt_stat;
         dma_ff <= nxt_dma;
         str_ff <= nxt_str;
         typ_ff <= nxt_typ;
         mux_ff <= nxt_mux;
         rdata_ff <= nxt_rdata;
         pout_ff <= nxt_pout;
         poe_ff <= nxt_poe;
         pin_ff <= nxt_pin;
         claim_ff <= nxt_claim;
         irq_ff <= nxt_irq;
         irqp_ff <= nxt_irqp;
         dma_trig_ff <= nxt_dma_trig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output ports.
   assign RDATA = rdata_ff;
   assign PAD_OUT = pout_ff;
   assign PAD_OE = poe_ff;
   assign PAD_STRENGTH = str_ff;
   assign PAD_TYPE = typ_ff;
   assign PERIPH_IN = pin_ff;
   assign CLAIM_OUT = claim_ff;
   assign IRQ = irq_ff;
   assign IRQ_PIN = irqp_ff;
   assign DMA_TRIG = dma_trig_ff;
endmodule
`default_nettype wire

// ===== hdl/gpm_sense.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_sense
   import gpm_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   gpm_sense_if.det sif
);
   logic [7:0] meta_ff;
   logic [7:0] sync_ff;
   logic [7:0] prev_ff;
   logic [7:0] nxt_meta;
   logic [7:0] nxt_sync;
   logic [7:0] nxt_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser plus one history stage for edge detection.
   always_comb
   begin
      nxt_meta = sif.pin_raw;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
   end

   // Stages reset low, so a pad already high shows a rising edge just after release.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_ff <= RST_BYTE;
         sync_ff <= RST_BYTE;
         prev_ff <= RST_BYTE;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

   assign sif.pin_lvl = sync_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin event decode; an unknown mode code raises nothing.
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      logic [2:0] md;
      logic rise;
      logic fall;
      assign md = sif.mode[i*MODE_W +: MODE_W];
      assign rise = sync_ff[i] & ~prev_ff[i];
      assign fall = ~sync_ff[i] & prev_ff[i];
      always_comb
      begin
         case (md)
            SENSE_FALLING: sif.evt[i] = fall;
            SENSE_RISING: sif.evt[i] = rise;
            SENSE_BOTH: sif.evt[i] = rise | fall;
            SENSE_LOW: sif.evt[i] = ~sync_ff[i];
            SENSE_HIGH: sif.evt[i] = sync_ff[i];
            default: sif.evt[i] = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== hdl/gpm_sense_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries pad levels into the sense detector and events back out.
interface gpm_sense_if;
   logic [7:0] pin_raw;
   logic [23:0] mode;
   logic [7:0] pin_lvl;
   logic [7:0] evt;
   modport det (input pin_raw, input mode, output pin_lvl, output evt);
   modport core (output pin_raw, output mode, input pin_lvl, input evt);
endinterface
`default_nettype wire

// ===== tb/gpm_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_model
   import gpm_pkg::*;
(
   input wire logic clk,
   input wire logic [gpm_pkg::NUM_PINS-1:0] ext_en,
   input wire logic [gpm_pkg::NUM_PINS-1:0] ext_lvl,
   input wire logic [gpm_pkg::NUM_PINS-1:0] pad_out,
   input wire logic [gpm_pkg::NUM_PINS-1:0] pad_oe,
   input wire logic [2*gpm_pkg::NUM_PINS-1:0] pad_type,
   output logic [gpm_pkg::NUM_PINS-1:0] pad_lvl
);
   // The port's own driver wins, then an outside source, then termination.
   // A pin with nothing on it wanders with the clock, so it never reads steady.
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (pad_oe[i])
            pad_lvl[i] = pad_out[i];
         else if (ext_en[i])
            pad_lvl[i] = ext_lvl[i];
         else if (pad_type[2*i+:2] == DRV_PULL_UP)
            pad_lvl[i] = 1'b1;
         else if (pad_type[2*i+:2] == DRV_PULL_DOWN)
            pad_lvl[i] = 1'b0;
         else
            pad_lvl[i] = clk ^ i[0];
      end
   end
endmodule
`default_nettype wire

// ===== tb/gpm_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_port_asserts
   import gpm_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic [gpm_pkg::ADDR_W-1:0] ADDR,
   input wire logic [gpm_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [gpm_pkg::DATA_W-1:0] RDATA,
   input wire logic [gpm_pkg::NUM_PINS-1:0] PAD_IN,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] PERIPH_IN,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] PEER_CLAIM,
   input wire logic [gpm_pkg::NUM_FUNCS-1:0] CLAIM_OUT,
   input wire logic IRQ,
   input wire logic [gpm_pkg::NUM_PINS-1:0] IRQ_PIN,
   input wire logic DMA_TRIG
);
   logic [7:0] sel_ff, en_ff, disc_ff, dma_ff, nxt_sel, nxt_en, nxt_disc, nxt_dma;
   logic [1:0] age_ff, nxt_age;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow copies of the enables, so outputs are judged without the register file.
   always_comb
   begin
      nxt_sel = (WR && ADDR == OFS_SELECT) ? WDATA[7:0] : sel_ff;
      nxt_en = (WR && ADDR == OFS_IRQ_EN) ? WDATA[7:0] : en_ff;
      nxt_dma = (WR && ADDR == OFS_DMA_EN) ? WDATA[7:0] : dma_ff;
      nxt_disc = (WR && ADDR == OFS_DISCRETE) ? WDATA[7:0] : (WR && ADDR == OFS_SENSE) ?
         (WDATA[SENSE_DISC_BIT] ? (disc_ff | sel_ff) : (disc_ff & ~sel_ff)) : disc_ff;
      nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
   end
   // The age count hides the first edges, while the pad synchronisers still hold reset zeros.
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         {sel_ff, en_ff, dma_ff, disc_ff, age_ff} <= '0;
      else
         {sel_ff, en_ff, dma_ff, disc_ff, age_ff} <= {nxt_sel, nxt_en, nxt_dma, nxt_disc, nxt_age};
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   rd_idle_a: assert property (!RD |=> RDATA == '0)
      else $error("Read data not zero outside a read reply.");
   rd_mask_a: assert property (RD && ADDR == OFS_DATA |=>
      RDATA[31:8] == '0 && (RDATA[7:0] & ~$past(sel_ff)) == '0)
      else $error("Unselected pin bit set in a pin read.");
   pin_read_a: assert property (RD && ADDR == OFS_DATA && age_ff == 2'h3 && $stable(PAD_IN) &&
      PAD_IN == $past(PAD_IN, 2) && PAD_IN == $past(PAD_IN, 3) |=> RDATA[7:0] == ($past(PAD_IN) & $past(sel_ff)))
      else $error("Pin read does not match the pad level.");
   peer_claim_a: assert property ($stable(PEER_CLAIM) |-> (CLAIM_OUT & PEER_CLAIM) == '0 && !CLAIM_OUT[0])
      else $error("Function routed although a lower port claims it.");
   periph_idle_a: assert property (CLAIM_OUT == '0 && $past(CLAIM_OUT) == '0 && $past(CLAIM_OUT, 2) == '0
      |-> PERIPH_IN == '0)
      else $error("Peripheral input driven with no routed function.");
   irq_pin_en_a: assert property (!$past(WR) && !$past(WR, 2) |-> (IRQ_PIN & ~(en_ff & disc_ff)) == '0)
      else $error("Per-pin interrupt without discrete mode and enable.");
   irq_shared_en_a: assert property (!$past(WR) && !$past(WR, 2) && (en_ff & ~disc_ff) == '0 |-> !IRQ)
      else $error("Shared interrupt high with no shared source enabled.");
   dma_en_a: assert property (!$past(WR) && !$past(WR, 2) && dma_ff == '0 |-> !DMA_TRIG)
      else $error("Trigger pulse with no trigger pin enabled.");
   cover property ($rose(IRQ));
   cover property (DMA_TRIG);
   cover property (IRQ_PIN != '0);
   cover property (CLAIM_OUT != '0);
endmodule
`default_nettype wire

// ===== tb/gpm_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_port_bench;
   import gpm_pkg::*;
   logic clk, arst_n, wr, rd, irq, dma_trig;
   logic [7:0] addr, pad_in, pad_out, pad_oe, irq_pin, ext_en, ext_lvl, b, dir, sel, d, lvl;
   logic [31:0] wdata, rdata;
   logic [15:0] pad_strength, pad_type, periph_out, periph_oe, periph_in, peer_claim, claim_out;
   logic [2:0] modes [5];
   int n_fail, tests_run, seed, dma_cnt, c0;
   gpm_port u_gpm_port (.CORE_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
      .PAD_STRENGTH(pad_strength), .PAD_TYPE(pad_type), .PERIPH_OUT(periph_out),
      .PERIPH_OE(periph_oe), .PERIPH_IN(periph_in), .PEER_CLAIM(peer_claim),
      .CLAIM_OUT(claim_out), .IRQ(irq), .IRQ_PIN(irq_pin), .DMA_TRIG(dma_trig));
   gpm_pin_model u_gpm_pin_model (.clk(clk), .ext_en(ext_en), .ext_lvl(ext_lvl),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_type(pad_type), .pad_lvl(pad_in));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, trigger pulse counter and watchdog.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (dma_trig === 1'b1) dma_cnt++;
   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Looks a step after the edge, so a flop launched on that edge has settled.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      #1;
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {addr, wdata, wr} <= {a, v, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // The reply stands only in the cycle after the strobe, so it is sampled there.
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Resets every pin to falling sense first; pads are held still meanwhile.
   task automatic sense(input logic [7:0] pins, input logic [31:0] v);
      wreg(OFS_SELECT, 32'h000000ff);
      wreg(OFS_SENSE, 32'h00000000);
      wreg(OFS_SELECT, {24'h000000, pins});
      wreg(OFS_SENSE, v);
   endtask
   // Status expected after the pin reaches lvl; a level bit set before a move stays sticky.
   function automatic logic hit(input logic [2:0] m, input logic lvl, input logic moved);
      return (moved && m != (lvl ? SENSE_FALLING : SENSE_RISING)) || m == (lvl ? SENSE_HIGH : SENSE_LOW);
   endfunction
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      seed = 50;
      arst_n = 1'b0;
      {wr, rd, addr, wdata, ext_lvl, periph_out, periph_oe, peer_claim} = '0;
      ext_en = 8'hff;
      modes = '{SENSE_FALLING, SENSE_RISING, SENSE_BOTH, SENSE_HIGH, SENSE_LOW};
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      for (int a = 0; a <= 'h30; a += 4) rreg(a[7:0], 32'h00000000);
      for (int i = 0; i < 5; i++)
      begin
         b = 8'h01 << i;
         sense(b, {29'h0, modes[i]});
         wreg(OFS_IRQ_EN, {24'h0, b});
         wreg(OFS_DMA_EN, {24'h0, b});
         c0 = dma_cnt;
         pause(6);
         rreg(OFS_RAW_STAT, hit(modes[i], 0, 0) ? b : 8'h00);
         rreg(OFS_RAW_STAT, hit(modes[i], 0, 0) ? b : 8'h00);
         ext_lvl <= b;
         pause(6);
         chk(irq, hit(modes[i], 1, 1));
         rreg(OFS_MASK_STAT, hit(modes[i], 1, 1) ? b : 8'h00);
         rreg(OFS_RAW_STAT, hit(modes[i], 1, 0) ? b : 8'h00);
         ext_lvl <= 8'h00;
         pause(6);
         wreg(OFS_IRQ_EN, 32'h0);
         pause(3);
         chk(irq, 1'b0);
         rreg(OFS_RAW_STAT, hit(modes[i], 0, 1) ? b : 8'h00);
         if (i < 3) chk(dma_cnt - c0, hit(modes[i], 1, 1) + hit(modes[i], 0, 1));
      end
      sense(8'hff, 32'h0);
      rreg(OFS_RAW_STAT, 32'h10);
      rreg(OFS_RAW_STAT, 32'h00);
      sense(8'h20, {28'h0, 1'b1, SENSE_RISING});
      wreg(OFS_IRQ_EN, 32'h20);
      ext_lvl <= 8'h20;
      pause(6);
      chk(irq_pin, 8'h20);
      chk(irq, 1'b0);
      rreg(OFS_MASK_STAT, 32'h20);
      pause(2);
      chk(irq_pin, 8'h00);
      wreg(OFS_IRQ_EN, 32'h0);
      wreg(OFS_DMA_EN, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         {dir, sel, d, lvl} = $random(seed);
         ext_lvl <= lvl;
         wreg(OFS_SELECT, 32'hff);
         wreg(OFS_DIR, {24'h0, dir});
         wreg(OFS_DATA, {24'h0, d});
         wreg(OFS_SELECT, {24'h0, sel});
         wreg(OFS_DATA, {24'h0, ~d});
         pause(5);
         chk(pad_out, {24'h0, d ^ sel});
         chk(pad_oe, {24'h0, dir});
         rreg(OFS_DATA, {24'h0, (((d ^ sel) & dir) | (lvl & ~dir)) & sel});
      end
      wreg(OFS_DIR, 32'h0);
      ext_en <= 8'hfb;
      wreg(OFS_SELECT, 32'h04);
      wreg(OFS_DRV_TYPE, {30'h0, DRV_PULL_UP});
      wreg(OFS_STRENGTH, 32'h3);
      pause(4);
      chk(pad_type, 16'h0010);
      rreg(OFS_DRV_TYPE, 32'h10);
      rreg(OFS_STRENGTH, 32'h00);
      rreg(OFS_DATA, 32'h04);
      wreg(OFS_DIR, 32'h04);
      rreg(OFS_STRENGTH, 32'h30);
      chk(pad_strength, 16'h0030);
      wreg(OFS_SELECT, 32'h02);
      wreg(OFS_MUX, 32'h5);
      {periph_out, periph_oe} <= {16'h0020, 16'h0020};
      pause(5);
      chk(claim_out, 16'h0020);
      chk(pad_oe, 8'h06);
      chk(periph_in, 16'h0020);
      rreg(OFS_MUX, 32'h50);
      peer_claim <= 16'h0020;
      pause(5);
      chk(claim_out, 16'h0000);
      chk(pad_oe, 8'h04);
      chk(periph_in, 16'h0000);
      conclude();
   end
endmodule
bind gpm_port gpm_port_asserts u_gpm_port_asserts (.CORE_CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD,
   .RDATA, .PAD_IN, .PERIPH_IN, .PEER_CLAIM, .CLAIM_OUT, .IRQ, .IRQ_PIN, .DMA_TRIG);
`default_nettype wire
